//--- dv/data_mem_model.sv
/*
  data memory model on the far side of the address unit.
  assumes a write lands at the edge where o_mem_valid is seen.
*/
module data_mem_model (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic i_write,
  input wire logic i_denied,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // one entry per byte address keeps the lookup a plain index; odd entries stay unused
  logic [15:0] mem [65536];
  // refused accesses must never reach the array
  always @(posedge i_clk)
  begin
    if (i_valid && i_write && !i_denied)
      mem[i_addr] <= i_wdata;
  end
endmodule

//--- dv/stack_and_ea_generation_monitor.sv
/*
  concurrent checks on the stack and address unit ports.
  assumes one clock, async high reset, bound to the design top.
*/
module stack_and_ea_generation_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stk_valid,
  input wire agu_pkg::stack_op_type i_stk_op,
  input wire logic i_limit_we,
  input wire logic [15:0] i_limit_data,
  input wire logic i_ea_valid,
  input wire agu_pkg::addr_mode_type i_mode,
  input wire logic [15:0] i_pointer_reg,
  input wire logic [15:0] i_base_operand_reg,
  input wire logic [15:0] i_modifier,
  input wire logic [15:0] o_stack_pointer,
  input wire logic [15:0] o_stack_limit,
  input wire logic o_stack_error_trap,
  input wire logic o_mem_write,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_effective_address,
  input wire logic [15:0] o_ptr_value
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // request decode; stack requests win, so operand checks exclude them
  wire push = i_stk_valid && i_stk_op == agu_pkg::STK_PUSH;
  wire pop = i_stk_valid && i_stk_op == agu_pkg::STK_POP;
  wire ea_on = i_ea_valid && !i_stk_valid;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_push;
    push |=> o_stack_pointer == $past(o_stack_pointer) + 16'h0002 && o_mem_write && o_mem_addr == $past(o_stack_pointer);
  endproperty
  a_push: assert property (p_push) else $error("push address or step wrong");
  property p_pop;
    pop |=> o_stack_pointer == $past(o_stack_pointer) - 16'h0002 && o_mem_addr == o_stack_pointer;
  endproperty
  a_pop: assert property (p_pop) else $error("pop address or step wrong");
  property p_limit;
    i_limit_we |=> o_stack_limit == ($past(i_limit_data) & 16'hfffe);
  endproperty
  a_limit: assert property (p_limit) else $error("limit write wrong");
  property p_trap;
    o_stack_error_trap |-> $past(i_stk_valid) || $past(i_ea_valid);
  endproperty
  a_trap: assert property (p_trap) else $error("trap without request");
  property p_atlim;
    push && o_stack_pointer == o_stack_limit |=> !o_stack_error_trap;
  endproperty
  a_atlim: assert property (p_atlim) else $error("trap on push at limit");
  property p_pre;
    ea_on && i_mode == agu_pkg::MODE_PRE |=> o_effective_address == $past(i_pointer_reg) + $past(i_modifier);
  endproperty
  a_pre: assert property (p_pre) else $error("pre-modify address wrong");
  property p_post;
    ea_on && i_mode == agu_pkg::MODE_POST |=> o_effective_address == $past(i_pointer_reg)
      && o_ptr_value == $past(i_pointer_reg) + $past(i_modifier);
  endproperty
  a_post: assert property (p_post) else $error("post-modify wrong");
  property p_idx;
    ea_on && i_mode == agu_pkg::MODE_INDEXED |=> o_effective_address == $past(i_pointer_reg) + $past(i_base_operand_reg);
  endproperty
  a_idx: assert property (p_idx) else $error("indexed address wrong");
endmodule

bind stack_and_ea_generation stack_and_ea_generation_monitor i_mon (.i_clk, .i_rst, .i_stk_valid, .i_stk_op,
  .i_limit_we, .i_limit_data, .i_ea_valid, .i_mode, .i_pointer_reg, .i_base_operand_reg, .i_modifier,
  .o_stack_pointer, .o_stack_limit, .o_stack_error_trap, .o_mem_write, .o_mem_addr, .o_effective_address, .o_ptr_value);

//--- dv/test_stack_and_ea_generation.sv
/*
  self-checking bench for the stack and address unit with a memory model.
  assumes 50 mhz clock; inputs change on the falling edge.
*/
module test_stack_and_ea_generation;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst = 1, i_stk_valid = 0, i_limit_we = 0, i_ea_valid = 0, i_is_move = 0, i_dest_is_default_accumulating_reg = 0;
  agu_pkg::stack_op_type i_stk_op = agu_pkg::STK_NONE;
  agu_pkg::addr_mode_type i_mode = agu_pkg::MODE_FILE;
  logic [22:0] i_pc = 23'h7f1234;
  logic [7:0] i_status_low_byte = 8'ha5;
  logic [3:0] i_pointer_index = 4'h3;
  logic [12:0] i_file_address = 13'h1abc;
  logic [15:0] i_stk_data = 16'hbeef, i_limit_data = 16'h0807, i_pointer_reg = 16'h1230, i_base_operand_reg = 16'h0104;
  logic [15:0] i_first_source_reg = 16'h5a5a, i_literal = 16'h0028, i_modifier = 16'hfffe, i_move_address = 16'hc002;
  logic i_boot_secure_ram_en = 1, i_exec_in_boot = 0, i_secure_segment_ram_en = 1, i_exec_in_secure = 0;
  logic [15:0] i_boot_ram_lo = 16'h1000, i_boot_ram_hi = 16'h10ff, i_secure_ram_lo = 16'h2000, i_secure_ram_hi = 16'h20ff;
  logic [15:0] o_stack_pointer, o_stack_limit, o_mem_addr, o_mem_wdata, o_effective_address, o_operand1, o_ptr_value;
  logic o_stack_error_trap, o_mem_valid, o_mem_write, o_mem_denied, o_ea_is_memory, o_ea_is_literal, o_ptr_we;
  logic o_result_to_default_accumulating_reg;
  logic [3:0] o_ptr_index, o_result_index;
  int mismatches = 0, check_count = 0;
  typedef struct { agu_pkg::addr_mode_type mode; logic mv; logic mem; logic [15:0] ea; } row_type;
  // mode, move flag, memory flag, expected address
  row_type rows [9] = '{'{agu_pkg::MODE_INDIRECT, 0, 1, 16'h1230}, '{agu_pkg::MODE_POST, 0, 1, 16'h1230},
    '{agu_pkg::MODE_PRE, 0, 1, 16'h122e}, '{agu_pkg::MODE_INDEXED, 0, 1, 16'h1334},
    '{agu_pkg::MODE_LITOFF, 0, 1, 16'h1258}, '{agu_pkg::MODE_FILE, 0, 1, 16'h1abc},
    '{agu_pkg::MODE_FILE, 1, 1, 16'hc002}, '{agu_pkg::MODE_LIT5, 0, 0, 16'h0}, '{agu_pkg::MODE_DIRECT, 0, 0, 16'h0}};
  agu_pkg::stack_op_type ops [4] = '{agu_pkg::STK_PUSH, agu_pkg::STK_CALL, agu_pkg::STK_EXC, agu_pkg::STK_PUSH};
  logic [15:0] words [4] = '{16'hbeef, 16'h007f, 16'ha57f, 16'hbeef};
  logic [15:0] ptrs [3] = '{16'h0806, 16'h0808, 16'h07fe};
  logic [15:0] wins [4] = '{16'h1010, 16'h1010, 16'h20ff, 16'h20ff};

  stack_and_ea_generation #(.PC_W(23)) i_dut (.i_clk, .i_rst, .i_stk_valid, .i_stk_op, .i_pc, .i_status_low_byte,
    .i_stk_data, .i_limit_we, .i_limit_data, .i_ea_valid, .i_mode, .i_is_move, .i_dest_is_default_accumulating_reg, .i_pointer_index,
    .i_pointer_reg, .i_base_operand_reg, .i_first_source_reg, .i_literal, .i_modifier, .i_move_address,
    .i_file_address, .i_boot_secure_ram_en, .i_boot_ram_lo, .i_boot_ram_hi, .i_exec_in_boot, .i_secure_segment_ram_en,
    .i_secure_ram_lo, .i_secure_ram_hi, .i_exec_in_secure, .o_stack_pointer, .o_stack_limit, .o_stack_error_trap,
    .o_mem_valid, .o_mem_write, .o_mem_addr, .o_mem_wdata, .o_mem_denied, .o_effective_address, .o_ea_is_memory,
    .o_ea_is_literal, .o_operand1, .o_ptr_we, .o_ptr_index, .o_ptr_value, .o_result_to_default_accumulating_reg, .o_result_index);
  data_mem_model i_mem (.i_clk, .i_valid(o_mem_valid), .i_write(o_mem_write), .i_denied(o_mem_denied),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle requests; outputs are read a half cycle after the answer edge
  task stk(input agu_pkg::stack_op_type op);
    @(negedge i_clk) i_stk_valid = 1;
    i_stk_op = op;
    @(negedge i_clk) i_stk_valid = 0;
  endtask
  task ea(input agu_pkg::addr_mode_type m, input logic mv);
    @(negedge i_clk) i_ea_valid = 1;
    i_mode = m;
    i_is_move = mv;
    @(negedge i_clk) i_ea_valid = 0;
  endtask
  task pulse_reset();
    @(negedge i_clk) i_rst = 1;
    @(negedge i_clk) i_rst = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #10 i_clk = ~i_clk;
  end
  // watchdog: the whole run needs well under 300 cycles
  initial
  begin
    repeat (2000) @(posedge i_clk);
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (12) @(negedge i_clk);
    i_rst = 0;
    check("sp_reset", o_stack_pointer, 16'h0800);
    foreach (rows[k])
    begin
      i_dest_is_default_accumulating_reg = k[0];
      ea(rows[k].mode, rows[k].mv);
      check("ea_is_memory", o_ea_is_memory, rows[k].mem);
      check("mem_valid", o_mem_valid, rows[k].mem);
      check("ptr_we", o_ptr_we, rows[k].mode inside {agu_pkg::MODE_PRE, agu_pkg::MODE_POST});
      check("ptr_index", o_ptr_index, 4'h3);
      if (rows[k].mode inside {agu_pkg::MODE_PRE, agu_pkg::MODE_POST})
        check("ptr_value", o_ptr_value, 16'h122e);
      if (rows[k].mem)
        check("effective_address", o_effective_address, rows[k].ea);
      check("ea_is_literal", o_ea_is_literal, rows[k].mode == agu_pkg::MODE_LIT5);
      check("operand1", o_operand1, i_first_source_reg);
      check("result_to_default_accumulating_reg", o_result_to_default_accumulating_reg, i_dest_is_default_accumulating_reg);
      check("result_index", o_result_index, rows[k].mode == agu_pkg::MODE_FILE ? 4'h0 : 4'h3);
    end
    $display("address mode rows done");
    @(negedge i_clk) i_limit_we = 1;
    @(negedge i_clk) i_limit_we = 0;
    check("limit", o_stack_limit, 16'h0806);
    // next request is a push, never a read through the stack pointer
    foreach (ops[k])
    begin
      stk(ops[k]);
      check("push_addr", o_mem_addr, 16'h0800 + 16'(k * 2));
      check("sp_up", o_stack_pointer, 16'h0802 + 16'(k * 2));
      check("no_trap", o_stack_error_trap, 1'b0);
    end
    stk(agu_pkg::STK_PUSH);
    check("overflow", o_stack_error_trap, 1'b1);
    @(negedge i_clk);
    check("trap_pulse", o_stack_error_trap, 1'b0);
    foreach (words[k])
      check("pushed_word", i_mem.mem[16'h0800 + 16'(k * 2)], words[k]);
    $display("push and limit test done");
    pulse_reset();
    check("limit_kept", o_stack_limit, 16'h0806);
    stk(agu_pkg::STK_PUSH);
    stk(agu_pkg::STK_POP);
    check("pop_addr", o_mem_addr, 16'h0800);
    check("pop_trap", o_stack_error_trap, 1'b0);
    stk(agu_pkg::STK_POP);
    check("underflow", o_stack_error_trap, 1'b1);
    i_pointer_index = 4'hf;
    foreach (ptrs[k])
    begin
      i_pointer_reg = ptrs[k];
      ea(agu_pkg::MODE_INDIRECT, 0);
      check("sp_ea_trap", o_stack_error_trap, k != 0);
    end
    $display("stack error test done");
    i_pointer_index = 4'h3;
    foreach (wins[k])
    begin
      i_pointer_reg = wins[k];
      i_exec_in_boot = k[0] & ~k[1];
      i_exec_in_secure = k[0] & k[1];
      ea(agu_pkg::MODE_INDIRECT, 0);
      check("denied", o_mem_denied, !k[0]);
      check("mem_valid", o_mem_valid, k[0]);
    end
    $display("secure ram test done");
    summarize();
  end
endmodule

//--- hw/agu_pkg.sv
/*
  package for the stack and effective-address unit: modes, constants, reset values.
  assumes a 16-bit data path and byte addressing of data memory.
*/
package agu_pkg;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] SFR_TOP = 16'h0800;
  localparam logic [15:0] NEAR_SIZE = 16'h2000;
  localparam int unsigned FILE_ADDR_W = 13;
  localparam int unsigned LIT5_W = 5;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [3:0] SP_INDEX = 4'hf;
  localparam logic [3:0] DEFAULT_DEFAULT_ACCUMULATING_REG_INDEX = 4'h0;

  // address modes for the operand path
  typedef enum logic [2:0] {
    MODE_FILE = 3'h0,
    MODE_DIRECT = 3'h1,
    MODE_INDIRECT = 3'h3,
    MODE_POST = 3'h2,
    MODE_PRE = 3'h6,
    MODE_INDEXED = 3'h7,
    MODE_LITOFF = 3'h5,
    MODE_LIT5 = 3'h4
  } addr_mode_type;

  // stack operations
  typedef enum logic [2:0] {
    STK_NONE = 3'h0,
    STK_PUSH = 3'h1,
    STK_POP = 3'h3,
    STK_CALL = 3'h2,
    STK_EXC = 3'h6
  } stack_op_type;
endpackage

//--- hw/stack_and_ea_generation.sv
/*
  stack pointer, stack limit checking and effective address generation.
  assumes decode presents one request per cycle as a valid pulse with its fields,
  and that data memory takes o_mem_* in the same cycle they are valid.
  the stack limit has no reset value; software writes it before the first stack access.
*/
// Function
// - pointer marks next free word, grows upward
// - push uses then increments, pop decrements first
// - call push zero-fills above the high program counter bits
// - exception push adds status low byte
// - limit not reset, bit zero reads zero
// - stack pointer addresses checked against limit
// - push at limit ok, next push traps
// - pointer below 0x0800 raises underflow trap
// - thirteen-bit direct file address, near space
// - default working register zero is destination
// - move reaches entire data space
// - first source always a working register
// - second source register, memory or literal
// - result to working register or memory
// - indirect uses unmodified pointer as address
// - post-modify accesses then steps pointer
// - pre-modify adds signed constant then accesses
// - indexed adds pointer and base register
// - literal offset adds pointer and literal
// - boot secure ram only from boot code
// - secure segment ram only from secure code
module stack_and_ea_generation #(
  parameter int unsigned PC_W = 23
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // stack request
  input wire logic i_stk_valid,
  input wire agu_pkg::stack_op_type i_stk_op,
  input wire logic [PC_W-1:0] i_pc,
  input wire logic [7:0] i_status_low_byte,
  input wire logic [15:0] i_stk_data,
  // stack limit write
  input wire logic i_limit_we,
  input wire logic [15:0] i_limit_data,
  // operand address request
  input wire logic i_ea_valid,
  input wire agu_pkg::addr_mode_type i_mode,
  input wire logic i_is_move,
  input wire logic i_dest_is_default_accumulating_reg,
  input wire logic [3:0] i_pointer_index,
  input wire logic [15:0] i_pointer_reg,
  input wire logic [15:0] i_base_operand_reg,
  input wire logic [15:0] i_first_source_reg,
  input wire logic [15:0] i_literal,
  input wire logic [15:0] i_modifier,
  input wire logic [15:0] i_move_address,
  input wire logic [12:0] i_file_address,
  // ram protection
  input wire logic i_boot_secure_ram_en,
  input wire logic [15:0] i_boot_ram_lo,
  input wire logic [15:0] i_boot_ram_hi,
  input wire logic i_exec_in_boot,
  input wire logic i_secure_segment_ram_en,
  input wire logic [15:0] i_secure_ram_lo,
  input wire logic [15:0] i_secure_ram_hi,
  input wire logic i_exec_in_secure,
  // outputs
  output logic [15:0] o_stack_pointer,
  output logic [15:0] o_stack_limit,
  output logic o_stack_error_trap,
  output logic o_mem_valid,
  output logic o_mem_write,
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic o_mem_denied,
  output logic [15:0] o_effective_address,
  output logic o_ea_is_memory,
  output logic o_ea_is_literal,
  output logic [15:0] o_operand1,
  output logic o_ptr_we,
  output logic [3:0] o_ptr_index,
  output logic [15:0] o_ptr_value,
  output logic o_result_to_default_accumulating_reg,
  output logic [3:0] o_result_index
);

  ////////////////////////////////////////////////////////////////////////////
  // stack state

  logic [15:0] stack_pointer_reg, stack_pointer_next;
  logic [15:0] stack_limit_reg;
  logic trap_reg, trap_next;

  // push kinds share the use-then-increment path
  wire op_push = (i_stk_op == agu_pkg::STK_PUSH);
  wire op_call = (i_stk_op == agu_pkg::STK_CALL);
  wire op_exc = (i_stk_op == agu_pkg::STK_EXC);
  wire is_push = i_stk_valid & (op_push | op_call | op_exc);
  wire is_pop = i_stk_valid & (i_stk_op == agu_pkg::STK_POP);
  // the pointer moves one word per access, so bit zero never changes
  wire [15:0] sp_inc = stack_pointer_reg + agu_pkg::STACK_STEP;
  wire [15:0] sp_dec = stack_pointer_reg - agu_pkg::STACK_STEP;
  wire [15:0] stack_addr = is_pop ? sp_dec : stack_pointer_reg;

  // upper program counter word, taken above bit 15
  wire [PC_W-17:0] pc_high = i_pc[PC_W-1:16];
  wire [15:0] call_word = {{(32-PC_W){1'b0}}, pc_high};
  wire [15:0] exc_word = {i_status_low_byte, 1'b0, pc_high[6:0]};

  // the pushed word: low pc, then formatted high half is left to decode sequencing
  logic [15:0] push_word;
  always_comb
  begin
    unique case (i_stk_op)
      agu_pkg::STK_CALL: push_word = call_word;
      agu_pkg::STK_EXC: push_word = exc_word;
      default: push_word = i_stk_data;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective address

  // every pointer-relative form is one 16-bit sum; carries out of bit 15 wrap on purpose
  function automatic logic [15:0] pointer_sum(input logic [15:0] base, input logic [15:0] offset);
    pointer_sum = base + offset;
  endfunction

  wire [15:0] pre_value = pointer_sum(i_pointer_reg, i_modifier);
  wire [15:0] post_value = pointer_sum(i_pointer_reg, i_modifier);
  wire [15:0] indexed_ea = pointer_sum(i_pointer_reg, i_base_operand_reg);
  wire [15:0] litoff_ea = pointer_sum(i_pointer_reg, i_literal);
  wire [15:0] file_ea = {3'h0, i_file_address};
  wire [15:0] lit5 = {11'h000, i_literal[agu_pkg::LIT5_W-1:0]};

  // one address per request; register direct and literals carry no memory address
  logic [15:0] ea_calc;
  always_comb
  begin
    unique case (i_mode)
      agu_pkg::MODE_FILE: ea_calc = i_is_move ? i_move_address : file_ea;
      agu_pkg::MODE_INDIRECT: ea_calc = i_pointer_reg;
      agu_pkg::MODE_POST: ea_calc = i_pointer_reg;
      agu_pkg::MODE_PRE: ea_calc = pre_value;
      agu_pkg::MODE_INDEXED: ea_calc = indexed_ea;
      agu_pkg::MODE_LITOFF: ea_calc = litoff_ea;
      agu_pkg::MODE_LIT5: ea_calc = lit5;
      default: ea_calc = i_pointer_reg;
    endcase
  end

  // memory vs register vs literal operand; direct stays in the register file
  wire ea_mem = i_ea_valid & (i_mode != agu_pkg::MODE_DIRECT) & (i_mode != agu_pkg::MODE_LIT5);
  wire ea_lit = i_ea_valid & (i_mode == agu_pkg::MODE_LIT5);
  wire ptr_update = i_ea_valid & ((i_mode == agu_pkg::MODE_POST) | (i_mode == agu_pkg::MODE_PRE));
  wire ea_uses_sp = ea_mem & (i_mode != agu_pkg::MODE_FILE) & (i_pointer_index == agu_pkg::SP_INDEX);
  // the updated pointer value written back to the stack pointer for an sp-based operand
  wire [15:0] ea_sp_view = ptr_update ? (i_mode == agu_pkg::MODE_PRE ? pre_value : post_value) : ea_calc;

  ////////////////////////////////////////////////////////////////////////////
  // limit and underflow checks

  // both bounds in one place: above the limit is overflow, below the floor underflow
  function automatic logic stack_fault(input logic [15:0] addr, input logic [15:0] limit);
    stack_fault = (addr > limit) | (addr < agu_pkg::SFR_TOP);
  endfunction

  // push at the limit writes fine; the address past it traps next time
  wire push_fault = is_push & stack_fault(stack_pointer_reg, stack_limit_reg);
  wire pop_fault = is_pop & stack_fault(sp_dec, stack_limit_reg);
  wire ea_fault = ea_uses_sp & stack_fault(ea_calc, stack_limit_reg);

  ////////////////////////////////////////////////////////////////////////////
  // ram protection

  function automatic logic in_window(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_window = (a >= lo) & (a <= hi);
  endfunction

  // stack requests own the memory port, so their address is the one checked
  wire [15:0] access_addr = i_stk_valid ? stack_addr : ea_calc;
  wire boot_block = i_boot_secure_ram_en & in_window(access_addr, i_boot_ram_lo, i_boot_ram_hi) &
                    ~i_exec_in_boot;
  wire secure_block = i_secure_segment_ram_en & in_window(access_addr, i_secure_ram_lo, i_secure_ram_hi) &
                      ~i_exec_in_secure;
  wire any_access = (i_stk_valid & (is_push | is_pop)) | ea_mem;
  wire denied = any_access & (boot_block | secure_block);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  // stack requests own the pointer; otherwise a stack-pointer operand may step it

  always_comb
  begin
    stack_pointer_next = stack_pointer_reg;
    if (is_push)
      stack_pointer_next = sp_inc;
    else if (is_pop)
      stack_pointer_next = sp_dec;
    else if (ptr_update & (i_pointer_index == agu_pkg::SP_INDEX))
      stack_pointer_next = {ea_sp_view[15:1], 1'b0};
  end

  // one cycle per faulting access
  assign trap_next = push_fault | pop_fault | ea_fault;

  // stack pointer; reset leaves it at the bottom of the stack area
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      stack_pointer_reg <= agu_pkg::SP_RESET;
    else
      stack_pointer_reg <= stack_pointer_next;
  end

  // trap request lasts exactly the cycle after the faulting access
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      trap_reg <= 1'b0;
    else
      trap_reg <= trap_next;
  end

  // limit is deliberately left out of reset; its low bit is forced clear
  // until written, limit checks see an unknown and the trap output can be unknown too
  always_ff @(posedge i_clk)
  begin
    if (i_limit_we)
      stack_limit_reg <= {i_limit_data[15:1], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered memory request and operand results

  // next values are named wires so the register blocks below stay plain copies
  wire mem_valid_next = any_access & ~denied;
  wire ptr_we_next = ptr_update & (i_pointer_index != agu_pkg::SP_INDEX);
  wire [15:0] ptr_value_next = (i_mode == agu_pkg::MODE_PRE) ? pre_value : post_value;
  wire result_to_default_accumulating_reg_next = i_ea_valid & i_dest_is_default_accumulating_reg;
  // file register forms always name the default working register
  wire [3:0] result_index_next = (i_mode == agu_pkg::MODE_FILE) ? agu_pkg::DEFAULT_DEFAULT_ACCUMULATING_REG_INDEX :
                                 i_pointer_index;

  // request towards data memory; a refused access keeps its address for the fault handler
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_mem_valid <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 16'h0000;
      o_mem_denied <= 1'b0;
    end
    else
    begin
      o_mem_valid <= mem_valid_next;
      o_mem_write <= is_push;
      o_mem_addr <= access_addr;
      o_mem_wdata <= push_word;
      o_mem_denied <= denied;
    end
  end

  // operand address and its kind; these follow the inputs every cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_effective_address <= 16'h0000;
      o_ea_is_memory <= 1'b0;
      o_ea_is_literal <= 1'b0;
      o_operand1 <= 16'h0000;
    end
    else
    begin
      o_effective_address <= ea_calc;
      o_ea_is_memory <= ea_mem;
      o_ea_is_literal <= ea_lit;
      o_operand1 <= i_first_source_reg;
    end
  end

  // pointer write-back and result routing for the register file
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ptr_we <= 1'b0;
      o_ptr_index <= 4'h0;
      o_ptr_value <= 16'h0000;
      o_result_to_default_accumulating_reg <= 1'b0;
      o_result_index <= 4'h0;
    end
    else
    begin
      o_ptr_we <= ptr_we_next;
      o_ptr_index <= i_pointer_index;
      o_ptr_value <= ptr_value_next;
      o_result_to_default_accumulating_reg <= result_to_default_accumulating_reg_next;
      o_result_index <= result_index_next;
    end
  end

  // state registers drive these ports directly, so they never glitch
  assign o_stack_pointer = stack_pointer_reg;
  assign o_stack_limit = stack_limit_reg;
  assign o_stack_error_trap = trap_reg;

endmodule
